// *** design/aux_timeout_timer.sv ***
// auxiliary bus timeout counter, restarted whenever run drops
// assumes run is held for the whole supervised cycle
`timescale 1ns/100ps
`default_nettype none

module aux_timeout_timer #(
    parameter int unsigned CYCLES_16MS = board_regs_pkg::PERIOD_16_CYCLES,
    parameter int unsigned CYCLES_64MS = board_regs_pkg::PERIOD_64_CYCLES,
    parameter int unsigned CYCLES_256MS = board_regs_pkg::PERIOD_256_CYCLES,
    parameter int unsigned CYCLES_1MS = board_regs_pkg::PERIOD_1_CYCLES
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // control side
    aux_timer_if.timer tmr
);

    logic [board_regs_pkg::TIMER_W-1:0] count;
    logic [board_regs_pkg::TIMER_W-1:0] limit;
    logic at_limit;

    // -------------------------------------------------------------------
    // period selection
    // -------------------------------------------------------------------
    assign limit = (tmr.period == board_regs_pkg::SEL_16_MS) ?
                       board_regs_pkg::TIMER_W'(CYCLES_16MS - 1) :
                   (tmr.period == board_regs_pkg::SEL_64_MS) ?
                       board_regs_pkg::TIMER_W'(CYCLES_64MS - 1) :
                   (tmr.period == board_regs_pkg::SEL_256_MS) ?
                       board_regs_pkg::TIMER_W'(CYCLES_256MS - 1) :
                       board_regs_pkg::TIMER_W'(CYCLES_1MS - 1);
    assign at_limit = tmr.run && (count >= limit);

    // -------------------------------------------------------------------
    // counter: clears while idle so every cycle gets a full period
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= '0;
            tmr.expired <= 1'b0;
        end else if (ce_i) begin
            count <= (tmr.run && !at_limit) ? count + 1'b1 : '0;
            tmr.expired <= at_limit;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_expiry_needs_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr.expired |-> $past(tmr.run))
        else $error("timer expired without a running cycle");
    a_count_in_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr.run && ce_i && $stable(tmr.period) |-> count <= limit)
        else $error("timer count passed the selected period");
    c_timer_expired: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr.expired);

endmodule : aux_timeout_timer

`default_nettype wire

// *** design/aux_timer_if.sv ***
// carrier between the register bank and its auxiliary bus timeout timer
// assumes both ends sit on the same host clock
`timescale 1ns/100ps
`default_nettype none

interface aux_timer_if;
    logic run;           // a supervised cycle is in flight
    logic [1:0] period;  // period select
    logic expired;       // one-cycle pulse at timeout

    modport ctrl (output run, output period, input expired);
    modport timer (input run, input period, output expired);
endinterface : aux_timer_if

`default_nettype wire

// *** design/board_regs_pkg.sv ***
// constants for the board system register bank: addresses, field positions, timing
// assumes a 125 MHz host clock and a little-endian 32-bit host data path
package board_regs_pkg;

    // -------------------------------------------------------------------
    // register addresses (byte addresses on the host memory bus)
    // -------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [19:0] BOARD_COMMAND_ADDR = 20'hd800e;
    localparam logic [19:0] BUS_ERROR_ADDRESS_ADDR = 20'hd8010;
    localparam logic [19:0] BUS_ERROR_MODIFIER_ADDR = 20'hd8014;
    localparam logic [19:0] BOARD_IDENTIFIER_ADDR = 20'hd8016;
    localparam logic [19:0] WORD_MASK = 20'hffffc;

    // -------------------------------------------------------------------
    // board_command field positions (within the 16-bit register)
    // -------------------------------------------------------------------
    localparam int MASTER_SWAP_BIT = 0;
    localparam int SLAVE_SWAP_BIT = 1;
    localparam int AUX_LOGIC_BIT = 2;
    localparam int AUX_TIMEOUT_BIT = 3;
    localparam int PERIOD_LO_BIT = 4;
    localparam int IRQ_ENABLE_BIT = 6;
    localparam int ERROR_FLAG_BIT = 7;
    localparam int WATCHDOG_BIT = 8;
    localparam int BYPASS_BIT = 10;
    localparam int BACKPLANE_BIT = 11;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam int MODIFIER_W = 6;

    // arbitrary neutral board number, stands in for the real one
    localparam logic [15:0] BOARD_ID_DEFAULT = 16'h0100;

    // -------------------------------------------------------------------
    // timeout periods
    // -------------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int PERIOD_16_MS = 16;
    localparam int PERIOD_64_MS = 64;
    localparam int PERIOD_256_MS = 256;
    localparam int PERIOD_1_MS = 1;
    localparam int PERIOD_16_CYCLES = PERIOD_16_MS * CLK_FREQ_KHZ;
    localparam int PERIOD_64_CYCLES = PERIOD_64_MS * CLK_FREQ_KHZ;
    localparam int PERIOD_256_CYCLES = PERIOD_256_MS * CLK_FREQ_KHZ;
    localparam int PERIOD_1_CYCLES = PERIOD_1_MS * CLK_FREQ_KHZ;
    localparam int TIMER_W = 25;
    localparam logic [1:0] SEL_16_MS = 2'h0;
    localparam logic [1:0] SEL_64_MS = 2'h1;
    localparam logic [1:0] SEL_256_MS = 2'h2;
    localparam logic [1:0] SEL_1_MS = 2'h3;

endpackage : board_regs_pkg

// *** design/board_system_regs.sv ***
// board system register bank beside the VMEbus bridge: swap control, timeout, error capture
// assumes host bus strobes and bridge status all on the host clock
//
// What this block does
// - master swap active when the master swap bit is 1, else data unswapped.
// - slave swap active when the slave swap bit is 1, else unswapped.
// - auxiliary bus-error logic acts only while its enable bit is 1.
// - auxiliary timeout timer runs only while the timeout enable bit is 1.
// - period select: 00 16 ms, 01 64 ms, 10 256 ms, 11 1 ms.
// - bus error raises the interrupt only while the interrupt enable is 1.
// - bus-error flag readable and cleared through the command register.
// - watchdog timeout drives SYSFAIL only while the routing bit is 1.
// - bypass bit set disables every endian swap.
// - board joins VMEbus activity only while the backplane enable is 1.
// - address bits 31..1 of the failed cycle captured in a 32-bit register.
// - six-bit modifier code of the failed cycle captured in low bits.
// - read-only 16-bit BCD board number, byte or word readable.
`timescale 1ns/100ps
`default_nettype none

module board_system_regs #(
    parameter int unsigned CYCLES_16MS = board_regs_pkg::PERIOD_16_CYCLES,
    parameter int unsigned CYCLES_64MS = board_regs_pkg::PERIOD_64_CYCLES,
    parameter int unsigned CYCLES_256MS = board_regs_pkg::PERIOD_256_CYCLES,
    parameter int unsigned CYCLES_1MS = board_regs_pkg::PERIOD_1_CYCLES,
    parameter logic [15:0] BOARD_ID = board_regs_pkg::BOARD_ID_DEFAULT
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // host memory bus
    input wire logic bus_sel_i,
    input wire logic bus_write_i,
    input wire logic [19:0] bus_addr_i,
    input wire logic [3:0] bus_be_i,
    input wire logic [31:0] bus_wdata_i,
    output logic [31:0] bus_rdata_o,
    output logic bus_ack_o,
    // VMEbus cycle status from the bridge
    input wire logic vme_cycle_start_i,
    input wire logic vme_cycle_done_i,
    input wire logic vme_berr_i,
    input wire logic [31:0] vme_addr_i,
    input wire logic [5:0] vme_am_i,
    input wire logic watchdog_timeout_i,
    // board controls
    output logic master_swap_o,
    output logic slave_swap_o,
    output logic backplane_enable_o,
    output logic aux_berr_o,
    output logic sysfail_o,
    output logic irq_o
);

    logic [15:0] command;
    logic [31:0] error_address;
    logic [5:0] error_modifier;
    logic error_flag;
    logic in_cycle;
    logic [31:0] next_rdata;
    aux_timer_if tmr ();

    // -------------------------------------------------------------------
    // address decode, aligned words on the 32-bit bus
    // -------------------------------------------------------------------
    wire [19:0] word_addr = bus_addr_i & board_regs_pkg::WORD_MASK;
    wire hit_cmd = word_addr == (board_regs_pkg::BOARD_COMMAND_ADDR & board_regs_pkg::WORD_MASK);
    wire hit_addr = word_addr == board_regs_pkg::BUS_ERROR_ADDRESS_ADDR;
    wire hit_mod = word_addr == board_regs_pkg::BUS_ERROR_MODIFIER_ADDR;
    wire wr = bus_sel_i && bus_write_i && ce_i;
    wire wr_cmd_lo = wr && hit_cmd && bus_be_i[2];  // command sits in the upper half
    wire wr_cmd_hi = wr && hit_cmd && bus_be_i[3];
    // flag clears by writing 1 to it, or by any write to the address register
    wire clear_flag = (wr_cmd_lo && bus_wdata_i[16 + board_regs_pkg::ERROR_FLAG_BIT])
                      || (wr && hit_addr && (bus_be_i != 4'h0));

    // -------------------------------------------------------------------
    // control decode
    // -------------------------------------------------------------------
    wire bypass = command[board_regs_pkg::BYPASS_BIT];
    wire aux_logic_en = command[board_regs_pkg::AUX_LOGIC_BIT];
    assign backplane_enable_o = command[board_regs_pkg::BACKPLANE_BIT];
    assign master_swap_o = command[board_regs_pkg::MASTER_SWAP_BIT] && !bypass;
    assign slave_swap_o = command[board_regs_pkg::SLAVE_SWAP_BIT] && !bypass;
    assign irq_o = error_flag && command[board_regs_pkg::IRQ_ENABLE_BIT];

    // -------------------------------------------------------------------
    // timer hookup; expiry counts only with the auxiliary logic enabled
    // -------------------------------------------------------------------
    assign tmr.run = in_cycle && backplane_enable_o
                     && command[board_regs_pkg::AUX_TIMEOUT_BIT];
    assign tmr.period = command[board_regs_pkg::PERIOD_LO_BIT +: 2];
    wire aux_expire = tmr.expired && aux_logic_en;
    assign aux_berr_o = aux_expire;
    // a disabled backplane sees no errors of its own
    wire error_event = backplane_enable_o && ((in_cycle && vme_berr_i) || aux_expire);
    // first error is kept; a clear in the same cycle frees the record
    wire capture = error_event && (!error_flag || clear_flag);

    aux_timeout_timer #(
        .CYCLES_16MS(CYCLES_16MS),
        .CYCLES_64MS(CYCLES_64MS),
        .CYCLES_256MS(CYCLES_256MS),
        .CYCLES_1MS(CYCLES_1MS)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .tmr(tmr)
    );

    // -------------------------------------------------------------------
    // command register, byte-wise writable; flag bit is not stored here
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            command <= board_regs_pkg::COMMAND_RESET;
        end else begin
            if (wr_cmd_lo) begin
                command[7:0] <= bus_wdata_i[23:16];
            end
            if (wr_cmd_hi) begin
                command[15:8] <= bus_wdata_i[31:24];
            end
        end
    end

    // -------------------------------------------------------------------
    // cycle tracking: a bus error or timeout ends the supervised cycle
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_cycle <= 1'b0;
        end else if (ce_i) begin
            in_cycle <= (in_cycle || vme_cycle_start_i) && !vme_cycle_done_i
                        && !vme_berr_i && !aux_expire;
        end
    end

    // -------------------------------------------------------------------
    // error record and flag; a new error beats a clear in the same cycle
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            error_flag <= 1'b0;
            error_address <= '0;
            error_modifier <= '0;
        end else if (ce_i) begin
            error_flag <= error_event || (error_flag && !clear_flag);
            if (capture) begin
                error_address <= {vme_addr_i[31:1], 1'b0};
                error_modifier <= vme_am_i;
            end
        end
    end

    // -------------------------------------------------------------------
    // watchdog routing; registered so the backplane driver sees no glitch
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sysfail_o <= 1'b0;
        end else if (ce_i) begin
            sysfail_o <= watchdog_timeout_i && command[board_regs_pkg::WATCHDOG_BIT];
        end
    end

    // -------------------------------------------------------------------
    // read mux; unmapped words read zero and still acknowledge
    // -------------------------------------------------------------------
    wire [15:0] cmd_view = {4'h0, command[11:10], 1'b0, command[8],
                            error_flag, command[6:0]};
    wire [15:0] mod_view = {{(16 - board_regs_pkg::MODIFIER_W){1'b0}}, error_modifier};
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_cmd) begin
            next_rdata = {cmd_view, 16'h0000};
        end else if (hit_addr) begin
            next_rdata = error_address;
        end else if (hit_mod) begin
            next_rdata = {BOARD_ID, mod_view};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= '0;
            bus_ack_o <= 1'b0;
        end else if (ce_i) begin
            bus_ack_o <= bus_sel_i;
            bus_rdata_o <= (bus_sel_i && !bus_write_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_master_swap_on: assert property (wr_cmd_lo && wr_cmd_hi && bus_wdata_i[16]
        && !bus_wdata_i[26] |=> master_swap_o)
        else $error("master swap not enabled after write");
    a_slave_swap_on: assert property (wr_cmd_lo && wr_cmd_hi && bus_wdata_i[17]
        && !bus_wdata_i[26] |=> slave_swap_o)
        else $error("slave swap not enabled after write");
    a_bypass_blocks_swap: assert property (wr_cmd_hi && bus_wdata_i[26]
        |=> !master_swap_o && !slave_swap_o)
        else $error("swap active under bypass");
    a_irq_follows_error: assert property (ce_i && error_event
        && command[board_regs_pkg::IRQ_ENABLE_BIT] && !wr_cmd_lo |=> irq_o)
        else $error("bus error did not raise interrupt");
    a_flag_needs_enable: assert property ($rose(error_flag) |-> $past(backplane_enable_o))
        else $error("error flagged with backplane disabled");
    a_capture_address: assert property ($rose(error_flag)
        |-> error_address[31:1] == $past(vme_addr_i) >> 1)
        else $error("error address not captured");
    a_capture_modifier: assert property ($rose(error_flag)
        |-> error_modifier == $past(vme_am_i))
        else $error("modifier code not captured");
    a_record_held: assert property (ce_i && error_flag && !clear_flag
        |=> $stable(error_address) && $stable(error_modifier))
        else $error("error record overwritten");
    a_sysfail_route: assert property (ce_i && watchdog_timeout_i
        && command[board_regs_pkg::WATCHDOG_BIT] |=> sysfail_o)
        else $error("watchdog did not reach sysfail");
    a_id_readback: assert property (ce_i && bus_sel_i && !bus_write_i && hit_mod
        |=> bus_ack_o && bus_rdata_o[31:16] == BOARD_ID)
        else $error("board number read wrong");
    a_timeout_is_error: assert property (ce_i && tmr.expired && aux_logic_en
        && backplane_enable_o |=> error_flag && !in_cycle)
        else $error("timeout did not end cycle with bus error");

    c_error_caught: cover property ($rose(error_flag));
    c_irq_raised: cover property ($rose(irq_o));
    c_sysfail_driven: cover property ($rose(sysfail_o));
    c_flag_cleared: cover property ($fell(error_flag));

endmodule : board_system_regs

`default_nettype wire

// *** tb/test_vme_board_system_regs.sv ***
// self-checking bench for the board system register bank
// assumes the bridge status model stands on the VMEbus side
`timescale 1ns/100ps
`default_nettype none

module test_vme_board_system_regs;
    // short timeout periods keep the run small
    localparam int unsigned C16 = 40;
    localparam int unsigned C64 = 80;
    localparam int unsigned C256 = 160;
    localparam int unsigned C1 = 20;
    // board number, value arbitrary
    localparam logic [15:0] BID = 16'h4321;
    localparam logic [19:0] CMD = board_regs_pkg::BOARD_COMMAND_ADDR;
    localparam logic [19:0] EADR = board_regs_pkg::BUS_ERROR_ADDRESS_ADDR;
    localparam logic [19:0] EMOD = board_regs_pkg::BUS_ERROR_MODIFIER_ADDR;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [19:0] addr = 20'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wd = 1'b0;
    logic [31:0] rdata, vaddr;
    logic [5:0] vam;
    logic ack, start, done, berr, mswap, sswap, bpe, aux, sysfail, irq;
    int n_mismatch = 0;
    int comparisons = 0;

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    board_system_regs #(.CYCLES_16MS(C16), .CYCLES_64MS(C64), .CYCLES_256MS(C256),
        .CYCLES_1MS(C1), .BOARD_ID(BID)) board_system_regs_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .bus_sel_i(sel), .bus_write_i(wr),
        .bus_addr_i(addr), .bus_be_i(be), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
        .bus_ack_o(ack), .vme_cycle_start_i(start), .vme_cycle_done_i(done),
        .vme_berr_i(berr), .vme_addr_i(vaddr), .vme_am_i(vam), .watchdog_timeout_i(wd),
        .master_swap_o(mswap), .slave_swap_o(sswap), .backplane_enable_o(bpe),
        .aux_berr_o(aux), .sysfail_o(sysfail), .irq_o(irq));

    vme_bridge_model vme_bridge_model_inst (.clk_i(clk_i), .start_o(start), .done_o(done),
        .berr_o(berr), .addr_o(vaddr), .am_o(vam));

    // -------------------------------------------------------------------
    // compare, bus and closing tasks
    // -------------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string s);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h", $time, s, got);
        end
    endtask : check_word

    task automatic give_verdict();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // one-cycle strobe; ack and read data are looked at in the following cycle
    task automatic access(input logic w, input logic [19:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk_i);
        sel = 1'b1;
        wr = w;
        addr = a;
        be = b;
        wdata = d;
        @(negedge clk_i);
        sel = 1'b0;
        check_word({31'h0, ack}, 32'h1, "ack");
        q = rdata;
    endtask : access

    task automatic put_cmd(input logic [15:0] v);
        logic [31:0] q;
        access(1'b1, CMD, 4'hc, {v, 16'h0}, q);
    endtask : put_cmd

    task automatic expect_reg(input logic [19:0] a, input logic [31:0] m,
        input logic [31:0] e, input string s);
        logic [31:0] q;
        access(1'b0, a, 4'hf, 32'h0, q);
        check_word(q & m, e, s);
    endtask : expect_reg

    // watch n cycles with no auxiliary bus error
    task automatic quiet(input int n, input string s);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge clk_i);
            seen = seen | aux;
        end
        check_word({31'h0, seen}, 32'h0, s);
    endtask : quiet

    // -------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        check_word({26'h0, mswap, sswap, bpe, aux, sysfail, irq}, 32'h0, "outputs");
        expect_reg(CMD, 32'hffffffff, 32'h0, "command reset");
        expect_reg(EADR, 32'hffffffff, 32'h0, "address reset");
        access(1'b1, EMOD, 4'hf, 32'hffffffff, q);
        expect_reg(EMOD, 32'hffffffff, {BID, 16'h0}, "board number");
        access(1'b0, 20'hd8017, 4'h8, 32'h0, q);
        check_word({24'h0, q[31:24]}, {24'h0, BID[15:8]}, "board number byte");
        expect_reg(20'hd8020, 32'hffffffff, 32'h0, "unmapped");
        $display("test reset done");
    endtask : t_reset

    task automatic t_controls();
        logic [15:0] tab [6] = '{16'h0001, 16'h0002, 16'h0003, 16'h0403, 16'h0800, 16'hffff};
        foreach (tab[i]) begin
            put_cmd(tab[i]);
            check_word({31'h0, mswap}, {31'h0, tab[i][0] & ~tab[i][10]}, "master");
            check_word({31'h0, sswap}, {31'h0, tab[i][1] & ~tab[i][10]}, "slave");
            check_word({31'h0, bpe}, {31'h0, tab[i][11]}, "backplane");
            expect_reg(CMD, 32'hffff0000, {tab[i] & 16'h0d7f, 16'h0}, "readback");
        end
        // a strobe with the clock enable low is ignored; one idle edge first so
        // the previous ack has dropped before the state freezes
        @(negedge clk_i);
        ce_i = 1'b0;
        sel = 1'b1;
        wr = 1'b1;
        addr = CMD;
        be = 4'hc;
        wdata = 32'h0;
        @(negedge clk_i);
        sel = 1'b0;
        @(negedge clk_i);
        check_word({31'h0, ack}, 32'h0, "ack with clock enable low");
        ce_i = 1'b1;
        expect_reg(CMD, 32'hffff0000, 32'h0d7f0000, "write while frozen");
        $display("test controls done");
    endtask : t_controls

    task automatic t_watchdog();
        put_cmd(16'h0100);
        wd = 1'b1;
        repeat (2) @(negedge clk_i);
        check_word({31'h0, sysfail}, 32'h1, "sysfail routed");
        put_cmd(16'h0000);
        @(negedge clk_i);
        check_word({31'h0, sysfail}, 32'h0, "sysfail blocked");
        wd = 1'b0;
        $display("test watchdog done");
    endtask : t_watchdog

    task automatic t_berr();
        logic [31:0] q;
        put_cmd(16'h0840);
        vme_bridge_model_inst.open_cycle(32'h89abcdef, 6'h2d);
        vme_bridge_model_inst.end_cycle(1'b1);
        @(negedge clk_i);
        check_word({31'h0, irq}, 32'h1, "irq on error");
        expect_reg(CMD, 32'h00800000, 32'h00800000, "flag set");
        vme_bridge_model_inst.open_cycle(32'h12345678, 6'h09);
        vme_bridge_model_inst.end_cycle(1'b1);
        expect_reg(EADR, 32'hffffffff, 32'h89abcdee, "error address");
        expect_reg(EMOD, 32'h0000003f, 32'h0000002d, "error modifier");
        put_cmd(16'h08c0);
        check_word({31'h0, irq}, 32'h0, "irq after clear");
        put_cmd(16'h0800);
        vme_bridge_model_inst.open_cycle(32'h00000a55, 6'h3e);
        vme_bridge_model_inst.end_cycle(1'b1);
        @(negedge clk_i);
        check_word({31'h0, irq}, 32'h0, "irq masked");
        expect_reg(EADR, 32'hffffffff, 32'h00000a54, "new record");
        access(1'b1, EADR, 4'hf, 32'h0, q);
        expect_reg(CMD, 32'h00800000, 32'h0, "clear by address word");
        put_cmd(16'h0000);
        vme_bridge_model_inst.open_cycle(32'h00000bbb, 6'h01);
        vme_bridge_model_inst.end_cycle(1'b1);
        expect_reg(CMD, 32'h00800000, 32'h0, "error while detached");
        $display("test bus error done");
    endtask : t_berr

    task automatic t_timeout();
        int unsigned per [4] = '{C16, C64, C256, C1};
        int cnt;
        for (int s = 0; s < 4; s++) begin
            put_cmd(16'h088c | 16'(s << 4));
            vme_bridge_model_inst.open_cycle(32'(32'hf0f0 + 4 * s), 6'h11);
            cnt = 1;
            while (aux !== 1'b1) begin
                @(negedge clk_i);
                cnt++;
                if (cnt > int'(per[s]) + 8) begin
                    n_mismatch++;
                    give_verdict();
                end
            end
            // cycle opens at the edge after start, expiry shows one period later
            check_word(32'(cnt), 32'(per[s] + 1), "timeout period");
            expect_reg(EADR, 32'hffffffff, 32'(32'hf0f0 + 4 * s), "timeout record");
            expect_reg(CMD, 32'h00800000, 32'h00800000, "timeout flag");
            vme_bridge_model_inst.release_bus();
        end
        put_cmd(16'h0888);
        vme_bridge_model_inst.open_cycle(32'h0000aaaa, 6'h11);
        quiet(2 * C16 + 4, "aux logic off");
        put_cmd(16'h0884);
        quiet(2 * C16 + 4, "timer off");
        expect_reg(CMD, 32'h00800000, 32'h0, "no flag when gated");
        vme_bridge_model_inst.end_cycle(1'b0);
        $display("test timeout done");
    endtask : t_timeout

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset();
        t_controls();
        t_watchdog();
        t_berr();
        t_timeout();
        give_verdict();
    end
endmodule : test_vme_board_system_regs

`default_nettype wire

// *** tb/vme_bridge_model.sv ***
// bridge status model: opens VMEbus cycles and ends them with done or bus error
// assumes the bench calls its tasks from code aligned to falling clock edges
`timescale 1ns/100ps
`default_nettype none

module vme_bridge_model (
    // clock
    input wire logic clk_i,
    // cycle status toward the register bank
    output logic start_o,
    output logic done_o,
    output logic berr_o,
    output logic [31:0] addr_o,
    output logic [5:0] am_o
);
    // idle lines; the address bus carries junk until a cycle drives it
    initial begin
        start_o = 1'b0;
        done_o = 1'b0;
        berr_o = 1'b0;
        addr_o = 32'h5a5a5a5a;
        am_o = 6'h2a;
    end

    // one start pulse; address and modifier stay put until the cycle ends
    task automatic open_cycle(input logic [31:0] a, input logic [5:0] m);
        @(negedge clk_i);
        addr_o = a;
        am_o = m;
        start_o = 1'b1;
        @(negedge clk_i);
        start_o = 1'b0;
    endtask : open_cycle

    // done or bus-error pulse, then the bus is let go
    task automatic end_cycle(input logic err);
        @(negedge clk_i);
        berr_o = err;
        done_o = ~err;
        @(negedge clk_i);
        berr_o = 1'b0;
        done_o = 1'b0;
        release_bus();
    endtask : end_cycle

    // a released bus shows the inverse of its last value, never a stale copy
    task automatic release_bus();
        addr_o = ~addr_o;
        am_o = ~am_o;
    endtask : release_bus
endmodule : vme_bridge_model

`default_nettype wire
